// File: pms_pkg.sv
// power mode switchback: shared constants, modes and states
// assumes a single free-running system clock domain
package pms_pkg;
    // power_config field positions
    localparam int unsigned PCFG_SLOW_BIT   = 0;
    localparam int unsigned PCFG_STOP_BIT   = 1;
    localparam int unsigned PCFG_SWB_BIT    = 2;
    localparam int unsigned PCFG_RSM_BIT    = 3;
    localparam int unsigned PCFG_PWE_BIT    = 4;
    localparam int unsigned PCFG_RSVD_BIT   = 5;
    localparam int unsigned PCFG_DBAUDB_BIT = 6;
    localparam int unsigned PCFG_DBAUDA_BIT = 7;
    localparam logic [7:0]  PCFG_RESET      = 8'h00;

    // slow clock divide ratio
    localparam int unsigned SLOW_DIV        = 100;
    // program address after a hardware reset
    localparam logic [23:0] RESUME_ADDR     = 24'h00_0000;
    // instructions to hold off interrupts after an enable/priority write
    localparam logic [1:0]  IRQ_DEFER_INSTR = 2'h1;

    typedef enum logic [1:0] {
        CM_FULL,
        CM_SLOW,
        CM_STOP
    } pms_clk_mode_type;

    typedef enum logic [2:0] {
        PM_FULL,
        PM_SLOW,
        PM_STOP,
        PM_OSC_WAIT,
        PM_CLK_ON
    } pms_state_type;
endpackage : pms_pkg

// File: pms_clk_if.sv
// carrier between the power controller and the clock enable generator
// assumes both ends run on clk_sys
`timescale 1ns/1ns
interface pms_clk_if;
    import pms_pkg::*;
    pms_clk_mode_type mode;
    logic             tick;
    modport ctrl (output mode, input tick);
    modport gen  (input mode, output tick);
endinterface : pms_clk_if

// File: pms_clk_gen.sv
// clock enable generator: full rate, divided, or stopped
// assumes downstream logic is clocked by clk_sys and qualified by tick
`timescale 1ns/1ns
module pms_clk_gen
    import pms_pkg::*;
#(
    parameter int unsigned DIV = pms_pkg::SLOW_DIV
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    pms_clk_if.gen    clk
);
    import pms_pkg::*;
    localparam int unsigned CW = $clog2(DIV);

    initial begin
        if (DIV < 2) begin
            $error("DIV must be at least 2");
        end
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } pms_gen_state_type;

    pms_gen_state_type r_reg;
    pms_gen_state_type r_next;

    // whole-cycle enables only, so a mode change never yields a short pulse
    always_comb begin
        r_next = r_reg;
        unique case (clk.mode)
            CM_FULL: begin
                r_next.tick = 1'b1;
                r_next.cnt  = CW'(DIV - 1);
            end
            CM_SLOW: begin
                if (r_reg.cnt == '0) begin
                    r_next.tick = 1'b1;
                    r_next.cnt  = CW'(DIV - 1);
                end else begin
                    r_next.tick = 1'b0;
                    r_next.cnt  = r_reg.cnt - 1'b1;
                end
            end
            CM_STOP: begin
                r_next.tick = 1'b0;
                r_next.cnt  = CW'(DIV - 1);
            end
            default: begin
                r_next.tick = 1'b0;
                r_next.cnt  = CW'(DIV - 1);
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_reg <= '{cnt: '0, tick: 1'b0};
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    assign clk.tick = r_reg.tick;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_slow_gap_ticks: assert property (
        (clk_en && r_reg.tick && clk.mode == CM_SLOW)
        |=> !r_reg.tick)
        else $error("slow mode ticked on consecutive cycles");
endmodule : pms_clk_gen

// File: pms_power_mode_switchback.sv
// power mode controller: slow mode switchback, stop mode entry and wake
// assumes clk_sys keeps running for this block; pins are asynchronous
// Summary of operation
// - with switchback enabled, interrupts or serial activity restore full speed
// - interrupt counts only when enabled, pending, acknowledged and not blocked
// - either external interrupt pin or a watchdog reset triggers switchback
// - uart a/b receive switchback comes from start-bit falling edge when enabled
// - loading uart a/b transmit buffer triggers switchback
// - switchback ignores serial interrupt flags
// - wake sources, each enabled, switch back through the wake interrupt
// - interrupt switchback takes effect the cycle after the event
// - writes to enable/priority registers defer interrupts one further instruction
// - transmit switchback at next instruction; receive switchback at edge cycle
// - setting the stop bit stops core and peripheral clocks
// - an eeprom flag decides whether oscillator and pll stop too
// - with oscillator off, only wake pin, uart c or reset end stop
// - hardware reset restarts the cpu at address zero
// - with both those enables clear, only reset ends stop
// - with oscillator running, any enabled wake source ends stop
// - oscillator restart, wait stable, clock on, then wake interrupt
// - oscillator running: clock on first, then wake interrupt
// - bit 7 and 6 double baud for uart a and b, bit 5 reserved
// - slow mode divides the clock by 100
// - hardware clears slow mode bit on switchback; software clears enable
`timescale 1ns/1ns
module pms_power_mode_switchback
    import pms_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             pcfg_wr,
    input  wire logic [7:0]       pcfg_wdata,
    output logic      [7:0]       pcfg_rdata,
    input  wire logic             instr_done,
    input  wire logic             ie_ip_write,
    input  wire logic             irq_ack,
    input  wire logic             ext_irq_a,
    input  wire logic             ext_irq_b,
    input  wire logic             ext_irq_a_en,
    input  wire logic             ext_irq_b_en,
    input  wire logic             ext_irq_a_blocked,
    input  wire logic             ext_irq_b_blocked,
    input  wire logic             wdt_reset,
    input  wire logic             uart_a_rx,
    input  wire logic             uart_b_rx,
    input  wire logic             uart_c_rx,
    input  wire logic             ring_indicator_in,
    input  wire logic             uart_a_rx_en,
    input  wire logic             uart_b_rx_en,
    input  wire logic             uart_a_tx_load,
    input  wire logic             uart_b_tx_load,
    input  wire logic             remote_wake_pin,
    input  wire logic             magic_pkt_evt,
    input  wire logic             wake_frame_evt,
    input  wire logic             int_link_up,
    input  wire logic             sec_link_up,
    input  wire logic             wake_pin_en,
    input  wire logic             magic_pkt_wake_en,
    input  wire logic             wake_frame_en,
    input  wire logic             frame_filter_en,
    input  wire logic             internal_link_wake_en,
    input  wire logic             secondary_link_wake_en,
    input  wire logic             uart_c_wake_en,
    input  wire logic             wake_irq_en,
    input  wire logic             osc_off_in_halt,
    input  wire logic             osc_stable,
    output logic                  core_clk_tick,
    output logic                  osc_pll_en,
    output logic                  wake_irq,
    output logic                  cpu_restart,
    output logic                  double_baud_a,
    output logic                  double_baud_b
);
    import pms_pkg::*;

    // pin synchronisers: s1 feeds only s2, edges compare s2 with d
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] d;
    } pms_sync_type;

    typedef struct packed {
        pms_state_type    st;
        logic [7:0]       pcfg;
        pms_sync_type     pin;
        logic [1:0]       defer;
        logic             tx_pend;
        logic             wake_irq;
        logic             restart;
        logic             osc_en;
        pms_clk_mode_type mode;
    } pms_ctrl_type;

    // pin vector order
    localparam int unsigned P_RXA = 0;
    localparam int unsigned P_RXB = 1;
    localparam int unsigned P_RXC = 2;
    localparam int unsigned P_RI  = 3;
    localparam int unsigned P_RWK = 4;
    localparam int unsigned P_OSC = 5;

    localparam pms_ctrl_type CTRL_RESET = '{
        st:       PM_FULL,
        pcfg:     PCFG_RESET,
        pin:      '{s1: 6'h0f, s2: 6'h0f, d: 6'h0f},
        defer:    2'h0,
        tx_pend:  1'b0,
        wake_irq: 1'b0,
        restart:  1'b1,
        osc_en:   1'b1,
        mode:     CM_FULL
    };

    pms_ctrl_type r_reg;
    pms_ctrl_type r_next;

    pms_clk_if clk_bus ();

    pms_clk_gen u_clk_gen (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .clk     (clk_bus.gen)
    );

    logic [5:0] pin_fall;
    logic       rwk_rise;
    logic       irq_ok;
    logic       qual_irq;
    logic       rx_sb;
    logic       tx_fire;
    logic       wake_any;
    logic       wake_osc;
    logic       switchback;

    always_comb begin
        pin_fall = r_reg.pin.d & ~r_reg.pin.s2;
        rwk_rise = r_reg.pin.s2[P_RWK] & ~r_reg.pin.d[P_RWK];
        irq_ok   = (r_reg.defer == 2'h0) && !ie_ip_write;
        qual_irq = irq_ok && irq_ack &&
                   ((ext_irq_a && ext_irq_a_en && !ext_irq_a_blocked) ||
                    (ext_irq_b && ext_irq_b_en && !ext_irq_b_blocked));
        rx_sb    = (pin_fall[P_RXA] && uart_a_rx_en) ||
                   (pin_fall[P_RXB] && uart_b_rx_en);
        tx_fire  = r_reg.tx_pend && instr_done;
        wake_osc = (rwk_rise && wake_pin_en) ||
                   ((pin_fall[P_RXC] || pin_fall[P_RI]) && uart_c_wake_en);
        wake_any = wake_osc ||
                   (magic_pkt_evt && magic_pkt_wake_en) ||
                   (wake_frame_evt && wake_frame_en && frame_filter_en) ||
                   (int_link_up && internal_link_wake_en) ||
                   (sec_link_up && secondary_link_wake_en);
        // serial interrupt flags play no part here
        switchback = r_reg.pcfg[PCFG_SWB_BIT] &&
                     (qual_irq || wdt_reset || rx_sb || tx_fire ||
                      (irq_ok && wake_any && wake_irq_en));
    end

    always_comb begin
        r_next          = r_reg;
        r_next.pin.s1   = {osc_stable, remote_wake_pin, ring_indicator_in,
                           uart_c_rx, uart_b_rx, uart_a_rx};
        r_next.pin.s2   = r_reg.pin.s1;
        r_next.pin.d    = r_reg.pin.s2;
        r_next.restart  = 1'b0;
        r_next.wake_irq = 1'b0;

        if (ie_ip_write && instr_done) begin
            r_next.defer = IRQ_DEFER_INSTR;
        end else if (instr_done && r_reg.defer != 2'h0) begin
            r_next.defer = r_reg.defer - 2'h1;
        end

        // a load in the same cycle as the firing keeps a fresh request
        if (uart_a_tx_load || uart_b_tx_load) begin
            r_next.tx_pend = 1'b1;
        end else if (tx_fire) begin
            r_next.tx_pend = 1'b0;
        end

        if (pcfg_wr && (r_reg.st == PM_FULL || r_reg.st == PM_SLOW)) begin
            r_next.pcfg = pcfg_wdata;
        end

        unique case (r_reg.st)
            PM_FULL, PM_SLOW: begin
                if (wake_any) begin
                    r_next.wake_irq = 1'b1;
                end
                if (r_next.pcfg[PCFG_STOP_BIT]) begin
                    r_next.st     = PM_STOP;
                    r_next.osc_en = !osc_off_in_halt;
                end else if (r_reg.st == PM_SLOW && switchback) begin
                    r_next.pcfg[PCFG_SLOW_BIT] = 1'b0;
                    r_next.st                  = PM_FULL;
                end else if (r_next.pcfg[PCFG_SLOW_BIT]) begin
                    r_next.st = PM_SLOW;
                end else begin
                    r_next.st = PM_FULL;
                end
            end
            PM_STOP: begin
                if (!r_reg.osc_en) begin
                    if (wake_osc) begin
                        r_next.st     = PM_OSC_WAIT;
                        r_next.osc_en = 1'b1;
                    end
                end else if (wake_any) begin
                    r_next.st = PM_CLK_ON;
                end
            end
            PM_OSC_WAIT: begin
                if (r_reg.pin.s2[P_OSC]) begin
                    r_next.st = PM_CLK_ON;
                end
            end
            PM_CLK_ON: begin
                // clock already enabled this cycle; interrupt follows
                r_next.wake_irq            = 1'b1;
                r_next.pcfg[PCFG_STOP_BIT] = 1'b0;
                r_next.st = r_reg.pcfg[PCFG_SLOW_BIT] ? PM_SLOW : PM_FULL;
            end
            default: begin
                r_next.st = PM_FULL;
            end
        endcase

        unique case (r_next.st)
            PM_FULL, PM_CLK_ON: r_next.mode = CM_FULL;
            PM_SLOW:            r_next.mode = CM_SLOW;
            PM_STOP, PM_OSC_WAIT: r_next.mode = CM_STOP;
            default:            r_next.mode = CM_STOP;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r_reg <= CTRL_RESET;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    assign clk_bus.mode  = r_reg.mode;
    assign core_clk_tick = clk_bus.tick;
    assign pcfg_rdata    = r_reg.pcfg;
    assign osc_pll_en    = r_reg.osc_en;
    assign wake_irq      = r_reg.wake_irq;
    assign cpu_restart   = r_reg.restart;
    assign double_baud_a = r_reg.pcfg[PCFG_DBAUDA_BIT];
    assign double_baud_b = r_reg.pcfg[PCFG_DBAUDB_BIT];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_stop_entry_gates: assert property (
        (clk_en && (r_reg.st == PM_FULL || r_reg.st == PM_SLOW) && pcfg_wr && pcfg_wdata[PCFG_STOP_BIT])
        |=> r_reg.st == PM_STOP && r_reg.mode == CM_STOP)
        else $error("stop bit did not stop the clocks");

    chk_osc_off_flag: assert property (
        (clk_en && (r_reg.st == PM_FULL || r_reg.st == PM_SLOW) && pcfg_wr && pcfg_wdata[PCFG_STOP_BIT])
        |=> r_reg.osc_en == !$past(osc_off_in_halt))
        else $error("oscillator state in stop does not follow flag");

    chk_no_wake_events: assert property (
        (r_reg.st == PM_STOP && !r_reg.osc_en && !wake_pin_en && !uart_c_wake_en)
        |=> r_reg.st == PM_STOP)
        else $error("stop left with both wake enables clear");

    chk_osc_before_irq: assert property (
        (r_reg.st == PM_OSC_WAIT && !r_reg.pin.s2[P_OSC])
        |=> !r_reg.wake_irq && r_reg.mode == CM_STOP && r_reg.osc_en)
        else $error("clock or interrupt before oscillator stable");

    chk_clock_then_irq: assert property (
        (clk_en && r_reg.st == PM_CLK_ON)
        |-> r_reg.mode == CM_FULL && !r_reg.wake_irq ##1 r_reg.wake_irq)
        else $error("wake interrupt not after clock restart");

    chk_rx_switchback: assert property (
        (clk_en && r_reg.st == PM_SLOW && r_reg.pcfg[PCFG_SWB_BIT] && !pcfg_wr &&
         pin_fall[P_RXA] && uart_a_rx_en)
        |=> !r_reg.pcfg[PCFG_SLOW_BIT] && r_reg.mode == CM_FULL)
        else $error("receive start edge missed switchback");

    chk_tx_next_instr: assert property (
        (clk_en && r_reg.st == PM_SLOW && r_reg.pcfg[PCFG_SWB_BIT] && !pcfg_wr &&
         r_reg.tx_pend && instr_done)
        |=> !r_reg.pcfg[PCFG_SLOW_BIT])
        else $error("transmit load missed switchback");

    chk_irq_defer_load: assert property (
        (clk_en && ie_ip_write && instr_done)
        |=> r_reg.defer == IRQ_DEFER_INSTR && !irq_ok)
        else $error("interrupt processing not deferred");

    chk_restart_pulse: assert property (
        (!sys_rst && $past(sys_rst))
        |-> cpu_restart && r_reg.st == PM_FULL)
        else $error("no restart pulse after reset");

    cov_osc_wake: cover property (r_reg.st == PM_OSC_WAIT ##[1:50] r_reg.st == PM_CLK_ON);
    cov_slow_back: cover property (r_reg.st == PM_SLOW ##1 r_reg.st == PM_FULL);
    cov_stop_run_wake: cover property (r_reg.st == PM_STOP && r_reg.osc_en ##1 r_reg.st == PM_CLK_ON);
endmodule : pms_power_mode_switchback

// File: pms_core_model.sv
// stand-in for the cpu core and the oscillator: instruction pulses and settle time
// assumes clk_sys keeps running while the oscillator is modelled as off
`timescale 1ns/1ns
module pms_core_model #(
    parameter int unsigned WS       = 0,
    parameter int unsigned OSC_WAIT = 8
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic core_clk_tick,
    input  wire logic osc_pll_en,
    output logic      instr_done,
    output logic      osc_stable
);
    int unsigned ws_cnt;
    int unsigned osc_cnt;

    // one instruction every WS+1 core ticks, so a slow core stretches the wait
    assign instr_done = core_clk_tick && (ws_cnt == WS);
    // stable only after the oscillator has run OSC_WAIT cycles
    assign osc_stable = osc_pll_en && (osc_cnt >= OSC_WAIT);

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !osc_pll_en)
            osc_cnt <= 0;
        else if (osc_cnt < OSC_WAIT)
            osc_cnt <= osc_cnt + 1;
        if (sys_rst)
            ws_cnt <= 0;
        else if (core_clk_tick)
            ws_cnt <= (ws_cnt == WS) ? 0 : ws_cnt + 1;
    end
endmodule : pms_core_model

// File: tb_pms_power_mode_switchback.sv
// self-checking bench for the power mode controller
// assumes the core model above supplies instruction pulses and oscillator status
`timescale 1ns/1ns
module tb_pms_power_mode_switchback;
    import pms_pkg::*;
    logic        clk_sys, sys_rst, clk_en, pcfg_wr, ie_ip_write, irq_ack, blk, wake_irq_en, osc_off_in_halt;
    logic [7:0]  pcfg_wdata, pcfg_rdata;
    logic [13:0] ev, en;
    logic        instr_done, osc_stable, core_clk_tick, osc_pll_en, wake_irq, cpu_restart;
    logic        double_baud_a, double_baud_b;
    int          n_fail, comparisons;
    wire  [3:0]  obs = {wake_irq, osc_pll_en, ~pcfg_rdata[0], core_clk_tick};

    pms_power_mode_switchback dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .pcfg_wr(pcfg_wr),
        .pcfg_wdata(pcfg_wdata), .pcfg_rdata(pcfg_rdata), .instr_done(instr_done),
        .ie_ip_write(ie_ip_write), .irq_ack(irq_ack), .ext_irq_a(ev[2]), .ext_irq_b(ev[3]),
        .ext_irq_a_en(en[2]), .ext_irq_b_en(en[3]), .ext_irq_a_blocked(blk), .ext_irq_b_blocked(blk),
        .wdt_reset(ev[4]), .uart_a_rx(~ev[5]), .uart_b_rx(~ev[6]), .uart_c_rx(~ev[12]),
        .ring_indicator_in(~ev[13]), .uart_a_rx_en(en[5]), .uart_b_rx_en(en[6]),
        .uart_a_tx_load(ev[0]), .uart_b_tx_load(ev[1]), .remote_wake_pin(ev[7]),
        .magic_pkt_evt(ev[8]), .wake_frame_evt(ev[9]), .int_link_up(ev[10]), .sec_link_up(ev[11]),
        .wake_pin_en(en[7]), .magic_pkt_wake_en(en[8]), .wake_frame_en(en[9]), .frame_filter_en(en[9]),
        .internal_link_wake_en(en[10]), .secondary_link_wake_en(en[11]), .uart_c_wake_en(en[12]),
        .wake_irq_en(wake_irq_en), .osc_off_in_halt(osc_off_in_halt), .osc_stable(osc_stable),
        .core_clk_tick(core_clk_tick), .osc_pll_en(osc_pll_en), .wake_irq(wake_irq),
        .cpu_restart(cpu_restart), .double_baud_a(double_baud_a), .double_baud_b(double_baud_b)
    );

    pms_core_model #(.WS(1), .OSC_WAIT(8)) core (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .core_clk_tick(core_clk_tick),
        .osc_pll_en(osc_pll_en), .instr_done(instr_done), .osc_stable(osc_stable)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic cyc();
        @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic wr(input logic [7:0] v);
        pcfg_wr = 1'b1;
        pcfg_wdata = v;
        cyc();
        pcfg_wr = 1'b0;
        cyc();
    endtask : wr

    task automatic wait_on(input int idx, input int lim);
        for (int i = 0; i < lim && obs[idx] !== 1'b1; i++) begin
            cyc();
        end
    endtask : wait_on

    task automatic t_reset();
        sys_rst = 1'b1;
        repeat (4) cyc();
        chk("restart_in_reset", 8'h01, cpu_restart);
        sys_rst = 1'b0;
        repeat (2) cyc();
        chk("pcfg_reset", PCFG_RESET, pcfg_rdata);
        chk("osc_after_reset", 8'h01, osc_pll_en);
        chk("tick_full_speed", 8'h01, core_clk_tick);
        chk("restart_released", 8'h00, cpu_restart);
    endtask : t_reset

    task automatic t_regs();
        wr(8'hf8);
        chk("pcfg_rw", 8'hf8, pcfg_rdata);
        chk("dbl_a_set", 8'h01, double_baud_a);
        chk("dbl_b_set", 8'h01, double_baud_b);
        wr(8'h40);
        chk("dbl_a_clr", 8'h00, double_baud_a);
        chk("dbl_b_kept", 8'h01, double_baud_b);
        wr(8'h00);
    endtask : t_regs

    task automatic t_slow();
        int n;
        wr(8'h01);
        wait_on(0, 120);
        n = 0;
        do begin
            cyc();
            n++;
        end while (core_clk_tick !== 1'b1 && n < 200);
        chk("slow_tick_gap", SLOW_DIV[7:0], n[7:0]);
        wr(8'h00);
    endtask : t_slow

    // slow mode, then one event source k with its enable e
    task automatic sb_case(input int k, input logic e, input logic switchback_enable);
        logic exp;
        exp = switchback_enable && (e || k == 0 || k == 1 || k == 4);
        en = '1;
        en[k] = e;
        if (k == 13)
            en[12] = e;
        wr({5'h00, switchback_enable, 2'b01});
        ev[k] = 1'b1;
        irq_ack = (k == 2 || k == 3);
        cyc();
        irq_ack = 1'b0;
        if (!(14'h30e0 >> k & 14'h0001))
            ev[k] = 1'b0;
        wait_on(1, (k < 2) ? 250 : 8);
        chk("switchback", exp, obs[1]);
        chk("swb_kept", switchback_enable, pcfg_rdata[2]);
        ev = '0;
        wr(8'h00);
        repeat (4) cyc();
    endtask : sb_case

    task automatic t_switch();
        for (int k = 0; k < 14; k++) begin
            sb_case(k, 1'b1, 1'b1);
            sb_case(k, 1'b0, 1'b1);
        end
        sb_case(0, 1'b1, 1'b0);
        sb_case(5, 1'b1, 1'b0);
        en = '1;
    endtask : t_switch

    // one cycle of external interrupt a, with or without acknowledge
    task automatic pulse_irq(input logic ack);
        ev[2] = 1'b1;
        irq_ack = ack;
        cyc();
        ev[2] = 1'b0;
        irq_ack = 1'b0;
        cyc();
    endtask : pulse_irq

    // run past the next instruction completion of the slow core
    task automatic wait_instr();
        for (int i = 0; i < 250 && instr_done !== 1'b1; i++) begin
            cyc();
        end
        cyc();
    endtask : wait_instr

    // blocked, unacknowledged, masked and deferred interrupts in slow mode
    task automatic t_irq_gate();
        wr(8'h05);
        blk = 1'b1;
        pulse_irq(1'b1);
        chk("irq_blocked", 8'h00, obs[1]);
        blk = 1'b0;
        pulse_irq(1'b0);
        chk("irq_no_ack", 8'h00, obs[1]);
        wake_irq_en = 1'b0;
        ev[8] = 1'b1;
        cyc();
        ev[8] = 1'b0;
        repeat (4) cyc();
        chk("wake_line_masked", 8'h00, obs[1]);
        wake_irq_en = 1'b1;
        ie_ip_write = 1'b1;
        wait_instr();
        ie_ip_write = 1'b0;
        pulse_irq(1'b1);
        chk("irq_deferred", 8'h00, obs[1]);
        wait_instr();
        pulse_irq(1'b1);
        chk("irq_after_defer", 8'h01, obs[1]);
        wr(8'h00);
    endtask : t_irq_gate

    task automatic t_stop_on();
        osc_off_in_halt = 1'b0;
        wr(8'h02);
        cyc();
        chk("stop_tick", 8'h00, core_clk_tick);
        chk("stop_osc_on", 8'h01, osc_pll_en);
        wr(8'h01);
        chk("stop_write_refused", 8'h02, pcfg_rdata);
        ev[8] = 1'b1;
        cyc();
        ev[8] = 1'b0;
        wait_on(3, 10);
        chk("wake_irq_on", 8'h01, wake_irq);
        chk("clock_before_irq", 8'h01, core_clk_tick);
        chk("stop_cleared", 8'h00, pcfg_rdata);
        cyc();
        chk("wake_irq_pulse", 8'h00, wake_irq);
    endtask : t_stop_on

    task automatic t_stop_off();
        osc_off_in_halt = 1'b1;
        wr(8'h02);
        cyc();
        chk("stop_osc_off", 8'h00, osc_pll_en);
        ev[8] = 1'b1;
        cyc();
        ev[8] = 1'b0;
        repeat (20) cyc();
        chk("packet_ignored", 8'h00, osc_pll_en);
        ev[7] = 1'b1;
        wait_on(2, 10);
        chk("osc_restart", 8'h01, osc_pll_en);
        chk("clock_waits", 8'h00, core_clk_tick);
        wait_on(3, 60);
        chk("wake_irq_off", 8'h01, wake_irq);
        chk("clock_on_irq", 8'h01, core_clk_tick);
        chk("osc_settled", 8'h01, osc_stable);
        ev = '0;
        repeat (4) cyc();
    endtask : t_stop_off

    task automatic t_no_wake();
        en[7] = 1'b0;
        en[12] = 1'b0;
        wr(8'h02);
        ev[7] = 1'b1;
        ev[12] = 1'b1;
        repeat (30) cyc();
        chk("no_wake_osc", 8'h00, osc_pll_en);
        chk("no_wake_stop", 8'h02, pcfg_rdata);
        ev = '0;
        en = '1;
        t_reset();
    endtask : t_no_wake

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end

    initial begin
        {clk_en, wake_irq_en, sys_rst} = 3'h7;
        {pcfg_wr, ie_ip_write, irq_ack, blk, osc_off_in_halt} = 5'h00;
        pcfg_wdata = 8'h00;
        ev = '0;
        en = '1;
        t_reset();
        t_regs();
        t_slow();
        t_switch();
        t_irq_gate();
        t_stop_on();
        t_stop_off();
        t_no_wake();
        close_out();
    end
endmodule : tb_pms_power_mode_switchback
